// File: design/bcse_engine.sv
// instruction sequencer of the bus controller with axi4-lite registers
// Behaviour
// - flag write: high byte of parameter clears flags, low byte sets them.
// - branch loads parameter into program counter when condition is true.
// - branch with blank condition code is always taken.
// - push-immediate writes the parameter onto the queue.
// - push-block-status writes last message block status onto the queue.
// - interrupt instruction raises host interrupt, parameter bit pattern kept readable.
// - push-memory reads shared RAM at parameter address, pushes that word.
// - push-time-tag writes current time tag onto the queue.
// - wait-trigger stalls until a rising trigger edge, then continues.
// - load-time-tag writes parameter into time tag; zero clears it.
// - plain execute runs message at parameter pointer, never flips.
// - time tag synchronise bit enables sync mode command support.
`timescale 1ns/100ps
`include "bcse_params.svh"
module bcse_engine (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // protocol unit
    output logic msg_start,
    output logic [15:0] msg_ptr,
    input wire logic msg_done,
    input wire logic msg_good,
    input wire logic [15:0] msg_block_status,
    output logic tt_sync_en,
    output logic [15:0] time_tag,
    // trigger and interrupt
    input wire logic external_trigger_input,
    output logic irq
);
    localparam int TT_CYC = `BCSE_TT_TICK_NS / `BCSE_CLK_NS;
    function automatic logic cond_true(input logic [3:0] c, input logic good,
                                       input logic [7:0] fl);
        logic r;
        r = 1'b0;
        if (c == bcse_pkg::BCSE_CC_ALWAYS) r = 1'b1;
        else if (c == bcse_pkg::BCSE_CC_GOOD) r = good;
        else if (c == bcse_pkg::BCSE_CC_BAD) r = !good;
        else if (c[3]) r = fl[c[2:0]];
        return r;
    endfunction
    function automatic logic map_ok(input logic [7:0] a);
        return (a[7:6] != 2'h0) ? (a[7:6] != 2'h3) : (a <= `BCSE_A_UIRQ);
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction
    bcse_pkg::bcse_state_type st_r;
    logic [31:0] imem [16];
    logic [15:0] sram [16];
    logic [15:0] gpq [16];
    logic [3:0] pc_r, q_wp_r, q_rp_r;
    logic [4:0] q_cnt_r;
    logic [7:0] flags_r;
    logic [15:0] tt_r, last_bs_r, user_irq_r;
    logic last_good_r, trig_d_r, ttsync_r;
    logic [2:0] int_stat_r, int_mask_r;
    logic [7:0] tick_cnt_r;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [7:0] wa_r;
    logic [31:0] wd_r, rdata_r;
    logic [3:0] ws_r;
    logic [1:0] bresp_r, rresp_r;
    wire [31:0] instr = imem[pc_r];
    wire [3:0] op = instr[`BCSE_OP_LSB +: 4];
    wire [3:0] cc = instr[`BCSE_CC_LSB +: 4];
    wire [15:0] param = instr[15:0];
    wire run = (st_r == bcse_pkg::BCSE_ST_RUN);
    wire ok = cond_true(cc, last_good_r, flags_r);
    wire take = run && ok;
    wire flip_hit = (op == bcse_pkg::BCSE_OP_FLIP) && cond_true(cc, msg_good, flags_r);
    wire msg_end = (st_r == bcse_pkg::BCSE_ST_MSG) && msg_done;
    wire [3:0] pc_inc = pc_r + 4'h1;
    wire trig_rise = external_trigger_input && !trig_d_r;
    wire tick = (tick_cnt_r == 8'(TT_CYC - 1));
    wire wr_go = aw_held_r && w_held_r && !bvalid_r;
    wire wr_ok = map_ok(wa_r);
    wire [31:0] wv = merge(32'h00000000, wd_r, ws_r);
    wire ar_go = arvalid && !rvalid_r;
    wire host_ctrl = wr_go && (wa_r == `BCSE_A_CTRL);
    wire host_start = host_ctrl && wv[`BCSE_CTRL_START];
    wire host_stop = host_ctrl && wv[`BCSE_CTRL_STOP];
    wire host_flags = wr_go && (wa_r == `BCSE_A_FLAGS) && ws_r[0];
    wire host_tt = wr_go && (wa_r == `BCSE_A_TTAG);
    wire host_imem = wr_go && (wa_r[7:6] == `BCSE_A_IMEM);
    wire host_sram = wr_go && (wa_r[7:6] == `BCSE_A_SRAM);
    wire q_full = (q_cnt_r == 5'h10);
    wire q_pop = ar_go && (araddr == `BCSE_A_QDATA) && (q_cnt_r != 5'h00);
    // push source
    logic push;
    logic [15:0] push_data;
    always_comb begin
        push = take;
        push_data = param;
        case (op)
            bcse_pkg::BCSE_OP_PSH_IMM: push_data = param;
            bcse_pkg::BCSE_OP_PSH_BS: push_data = last_bs_r;
            bcse_pkg::BCSE_OP_PSH_MEM: push_data = sram[param[3:0]];
            bcse_pkg::BCSE_OP_PSH_TT: push_data = tt_r;
            default: push = 1'b0;
        endcase
    end
    wire [2:0] int_set = {push, take && op == bcse_pkg::BCSE_OP_HALT,
                          take && op == bcse_pkg::BCSE_OP_IRQ};
    always_ff @(posedge clk) begin
        msg_start <= 1'b0;
        if (rst) begin
            st_r <= bcse_pkg::BCSE_ST_IDLE;
            pc_r <= 4'h0;
            msg_ptr <= 16'h0000;
            last_good_r <= 1'b0;
            last_bs_r <= 16'h0000;
            user_irq_r <= 16'h0000;
        end else if (host_stop) begin
            st_r <= bcse_pkg::BCSE_ST_IDLE;
        end else begin
            case (st_r)
                bcse_pkg::BCSE_ST_IDLE: begin
                    if (host_start) begin
                        st_r <= bcse_pkg::BCSE_ST_RUN;
                        pc_r <= 4'h0;
                    end
                end
                bcse_pkg::BCSE_ST_RUN: begin
                    pc_r <= pc_inc;
                    if (op == bcse_pkg::BCSE_OP_FLIP || (take && op == bcse_pkg::BCSE_OP_EXEC)) begin
                        st_r <= bcse_pkg::BCSE_ST_MSG;
                        msg_start <= 1'b1;
                        msg_ptr <= param;
                        pc_r <= pc_r;
                    end else if (take) begin
                        case (op)
                            bcse_pkg::BCSE_OP_HALT: st_r <= bcse_pkg::BCSE_ST_IDLE;
                            bcse_pkg::BCSE_OP_BRANCH: pc_r <= param[3:0];
                            bcse_pkg::BCSE_OP_IRQ: user_irq_r <= param;
                            bcse_pkg::BCSE_OP_WAIT: begin
                                st_r <= bcse_pkg::BCSE_ST_TRIG;
                                pc_r <= pc_r;
                            end
                            default: pc_r <= pc_inc;
                        endcase
                    end
                end
                bcse_pkg::BCSE_ST_MSG: begin
                    if (msg_done) begin
                        last_good_r <= msg_good;
                        last_bs_r <= msg_block_status;
                        pc_r <= pc_inc;
                        st_r <= bcse_pkg::BCSE_ST_RUN;
                    end
                end
                bcse_pkg::BCSE_ST_TRIG: begin
                    if (trig_rise) begin
                        pc_r <= pc_inc;
                        st_r <= bcse_pkg::BCSE_ST_RUN;
                    end
                end
                default: st_r <= bcse_pkg::BCSE_ST_IDLE;
            endcase
        end
    end
    wire [31:0] sram_wv = merge({16'h0000, sram[wa_r[5:2]]}, wd_r, ws_r);
    always_ff @(posedge clk) begin
        if (host_imem) imem[wa_r[5:2]] <= merge(imem[wa_r[5:2]], wd_r, ws_r);
        else if (msg_end && flip_hit) imem[pc_r][15:0] <= param ^ `BCSE_FLIP_MASK;
        if (host_sram) sram[wa_r[5:2]] <= sram_wv[15:0];
    end
    always_ff @(posedge clk) begin
        if (rst) flags_r <= `BCSE_FLAGS_RST;
        else if (host_flags) flags_r <= wd_r[7:0];
        else if (take && op == bcse_pkg::BCSE_OP_FLAG)
            flags_r <= (flags_r & ~param[`BCSE_FLAG_CLR_LSB +: 8]) | param[7:0];
    end
    // time tag, one count per microsecond
    always_ff @(posedge clk) begin
        trig_d_r <= external_trigger_input;
        if (rst) begin
            tick_cnt_r <= 8'h00;
            tt_r <= `BCSE_TT_RST;
        end else begin
            tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
            if (take && op == bcse_pkg::BCSE_OP_LOAD_TT) tt_r <= param;
            else if (host_tt) tt_r <= wd_r[15:0];
            else if (tick) tt_r <= tt_r + 16'h0001;
        end
    end
    // general purpose queue, oldest dropped when full
    always_ff @(posedge clk) begin
        if (push) gpq[q_wp_r] <= push_data;
        if (rst) begin
            q_wp_r <= 4'h0;
            q_rp_r <= 4'h0;
            q_cnt_r <= 5'h00;
        end else begin
            if (push) q_wp_r <= q_wp_r + 4'h1;
            if (q_pop || (push && q_full)) q_rp_r <= q_rp_r + 4'h1;
            if (push && !q_pop && !q_full) q_cnt_r <= q_cnt_r + 5'h01;
            else if (q_pop && !push) q_cnt_r <= q_cnt_r - 5'h01;
        end
    end
    // control, interrupt status and mask
    always_ff @(posedge clk) begin
        if (rst) begin
            ttsync_r <= `BCSE_CTRL_RST;
            int_stat_r <= 3'h0;
            int_mask_r <= `BCSE_IMASK_RST;
        end else begin
            if (host_ctrl) ttsync_r <= wv[`BCSE_CTRL_TTSYNC];
            if (wr_go && wa_r == `BCSE_A_IMASK) int_mask_r <= wv[2:0];
            if (wr_go && wa_r == `BCSE_A_ISTAT) int_stat_r <= (int_stat_r & ~wv[2:0]) | int_set;
            else int_stat_r <= int_stat_r | int_set;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `BCSE_RESP_OK;
            wa_r <= 8'h00;
            wd_r <= 32'h00000000;
            ws_r <= 4'h0;
        end else begin
            if (awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                wa_r <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wd_r <= wdata;
                ws_r <= wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? `BCSE_RESP_OK : `BCSE_RESP_ERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (araddr[7:6])
            `BCSE_A_IMEM: rd_mux = imem[araddr[5:2]];
            `BCSE_A_SRAM: rd_mux = {16'h0000, sram[araddr[5:2]]};
            default: begin
                case ({araddr[7:2], 2'b00})
                    `BCSE_A_CTRL: rd_mux = {29'h0, ttsync_r, 2'b00};
                    `BCSE_A_STAT: rd_mux = {24'h0, 2'b00, st_r, pc_r};
                    `BCSE_A_FLAGS: rd_mux = {24'h0, flags_r};
                    `BCSE_A_TTAG: rd_mux = {16'h0, tt_r};
                    `BCSE_A_QDATA: rd_mux = (q_cnt_r != 5'h00) ? {16'h0, gpq[q_rp_r]} : 32'h0;
                    `BCSE_A_QPTR: rd_mux = {19'h0, q_cnt_r, q_wp_r, q_rp_r};
                    `BCSE_A_ISTAT: rd_mux = {29'h0, int_stat_r};
                    `BCSE_A_IMASK: rd_mux = {29'h0, int_mask_r};
                    `BCSE_A_UIRQ: rd_mux = {16'h0, user_irq_r};
                    default: rd_mux = 32'h00000000;
                endcase
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `BCSE_RESP_OK;
        end else if (ar_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= map_ok({araddr[7:2], 2'b00}) ? `BCSE_RESP_OK : `BCSE_RESP_ERR;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign awready = !aw_held_r;
    assign wready = !w_held_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign tt_sync_en = ttsync_r;
    assign time_tag = tt_r;
    assign irq = |(int_stat_r & int_mask_r);
    flip_store_a: assert property (@(posedge clk) disable iff (rst)
        (msg_end && flip_hit && !host_imem) |=>
        imem[$past(pc_r)][15:0] == ($past(param) ^ 16'h0010))
        else $error("flipped pointer not stored");
    flag_write_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_FLAG && !host_flags) |=>
        flags_r == (($past(flags_r) & ~$past(param[15:8])) | $past(param[7:0])))
        else $error("flag write wrong");
    branch_taken_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_BRANCH && !host_stop) |=> pc_r == $past(param[3:0]))
        else $error("branch not taken");
    blank_branch_a: assert property (@(posedge clk) disable iff (rst)
        (run && !host_stop && op == bcse_pkg::BCSE_OP_BRANCH && cc == 4'h0) |=>
        pc_r == $past(param[3:0]))
        else $error("unconditional branch missed");
    push_imm_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_PSH_IMM) |=>
        (gpq[$past(q_wp_r)] == $past(param)) && (q_wp_r == 4'($past(q_wp_r) + 4'h1)))
        else $error("immediate push wrong");
    push_status_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_PSH_BS) |=> gpq[$past(q_wp_r)] == $past(last_bs_r))
        else $error("block status push wrong");
    irq_raise_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_IRQ && int_mask_r[0] && !host_stop) |=>
        user_irq_r == $past(param) ##1 irq)
        else $error("interrupt instruction lost");
    push_mem_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_PSH_MEM) |=>
        gpq[$past(q_wp_r)] == $past(sram[param[3:0]]))
        else $error("memory push wrong");
    push_tt_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_PSH_TT) |=> gpq[$past(q_wp_r)] == $past(tt_r))
        else $error("time tag push wrong");
    trig_wait_a: assert property (@(posedge clk) disable iff (rst)
        (st_r == bcse_pkg::BCSE_ST_TRIG && !trig_rise && !host_stop) |=>
        st_r == bcse_pkg::BCSE_ST_TRIG && $stable(pc_r))
        else $error("trigger wait left early");
    load_tt_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_LOAD_TT) |=> tt_r == $past(param))
        else $error("time tag load wrong");
    exec_msg_a: assert property (@(posedge clk) disable iff (rst)
        (take && op == bcse_pkg::BCSE_OP_EXEC && !host_stop) |=>
        msg_start && msg_ptr == $past(param) ##1 !msg_start)
        else $error("message launch wrong");
    cond_false_a: assert property (@(posedge clk) disable iff (rst)
        (run && !ok && !host_stop && !host_flags && op != bcse_pkg::BCSE_OP_FLIP) |=>
        pc_r == 4'($past(pc_r) + 4'h1) && !msg_start && $stable(flags_r))
        else $error("false condition had effect");
endmodule

// File: design/bcse_params.svh
// constants of the bus controller sequence engine
`ifndef BCSE_PARAMS_SVH
`define BCSE_PARAMS_SVH
`define BCSE_A_CTRL 8'h00
`define BCSE_A_STAT 8'h04
`define BCSE_A_FLAGS 8'h08
`define BCSE_A_TTAG 8'h0C
`define BCSE_A_QDATA 8'h10
`define BCSE_A_QPTR 8'h14
`define BCSE_A_ISTAT 8'h18
`define BCSE_A_IMASK 8'h1C
`define BCSE_A_UIRQ 8'h20
`define BCSE_A_IMEM 2'h1
`define BCSE_A_SRAM 2'h2
`define BCSE_CTRL_START 0
`define BCSE_CTRL_STOP 1
`define BCSE_CTRL_TTSYNC 2
`define BCSE_OP_LSB 20
`define BCSE_CC_LSB 16
`define BCSE_FLIP_MASK 16'h0010
`define BCSE_FLAG_CLR_LSB 8
`define BCSE_INT_IRQ 0
`define BCSE_INT_HALT 1
`define BCSE_INT_PUSH 2
`define BCSE_TT_TICK_NS 1000
`define BCSE_CLK_NS 5
`define BCSE_RESP_OK 2'h0
`define BCSE_RESP_ERR 2'h2
`define BCSE_FLAGS_RST 8'h00
`define BCSE_IMASK_RST 3'h0
`define BCSE_TT_RST 16'h0000
`define BCSE_CTRL_RST 1'h0
`endif

// File: design/bcse_pkg.sv
// types of the bus controller sequence engine
package bcse_pkg;
    typedef enum logic [3:0] {
        BCSE_OP_HALT = 4'h0,
        BCSE_OP_EXEC = 4'h1,
        BCSE_OP_FLIP = 4'h2,
        BCSE_OP_FLAG = 4'h3,
        BCSE_OP_BRANCH = 4'h4,
        BCSE_OP_PSH_IMM = 4'h5,
        BCSE_OP_PSH_BS = 4'h6,
        BCSE_OP_PSH_MEM = 4'h7,
        BCSE_OP_PSH_TT = 4'h8,
        BCSE_OP_IRQ = 4'h9,
        BCSE_OP_WAIT = 4'hA,
        BCSE_OP_LOAD_TT = 4'hB
    } bcse_op_type;
    typedef enum logic [3:0] {
        BCSE_CC_ALWAYS = 4'h0,
        BCSE_CC_GOOD = 4'h1,
        BCSE_CC_BAD = 4'h2
    } bcse_cc_type;
    typedef enum logic [1:0] {
        BCSE_ST_IDLE = 2'b00,
        BCSE_ST_RUN = 2'b01,
        BCSE_ST_MSG = 2'b10,
        BCSE_ST_TRIG = 2'b11
    } bcse_state_type;
endpackage

// File: sim/bcse_msg_model.sv
// protocol unit stand-in that answers message launches
`timescale 1ns/100ps
module bcse_msg_model (
    // clock
    input wire logic clk,
    // launch and result
    input wire logic msg_start,
    input wire logic [15:0] msg_ptr,
    output logic msg_done,
    output logic msg_good,
    output logic [15:0] msg_block_status,
    // scenario control
    input wire logic [7:0] lat,
    input wire logic [15:0] bad_a,
    input wire logic [15:0] bad_b
);
    logic [15:0] ptr;
    initial begin
        msg_done = 1'b0;
        msg_good = 1'b0;
        msg_block_status = 16'h0000;
        forever begin
            @(posedge clk);
            if (msg_start) begin
                ptr = msg_ptr;
                repeat (lat) @(posedge clk);
                msg_done <= 1'b1;
                msg_good <= (ptr !== bad_a) && (ptr !== bad_b);
                msg_block_status <= {((ptr === bad_a) || (ptr === bad_b)) ? 4'h9 : 4'h0, ptr[11:0]};
                @(posedge clk);
                // result lines invalid outside the done cycle
                msg_done <= 1'b0;
                msg_good <= ~msg_good;
                msg_block_status <= ~msg_block_status;
            end
        end
    end
endmodule

// File: sim/testbench.sv
// self-checking bench of the sequence engine
`timescale 1ns/100ps
`include "bcse_params.svh"
module testbench;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, msg_start, msg_done, msg_good, tt_sync_en, trig, irq;
    logic [7:0] awaddr, araddr, lat;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] msg_ptr, msg_block_status, time_tag, bad_a, bad_b;
    logic [15:0] ptr_log[$];
    logic [31:0] prog[$];
    int miscompares = 0;
    int cmp_count = 0;

    bcse_engine i_dut (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .msg_start(msg_start), .msg_ptr(msg_ptr),
        .msg_done(msg_done), .msg_good(msg_good), .msg_block_status(msg_block_status),
        .tt_sync_en(tt_sync_en), .time_tag(time_tag), .external_trigger_input(trig),
        .irq(irq));
    bcse_msg_model i_unit (.clk(clk), .msg_start(msg_start), .msg_ptr(msg_ptr),
        .msg_done(msg_done), .msg_good(msg_good), .msg_block_status(msg_block_status),
        .lat(lat), .bad_a(bad_a), .bad_b(bad_b));

    always @(posedge clk) begin
        if (msg_start) begin
            ptr_log.push_back(msg_ptr);
        end
    end

    task automatic results;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // handshakes judged at the rising edge, before its updates; bready and rready stay high
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic got;
        got = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            got = bvalid;
            resp = bresp;
        end
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        logic got;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            got = rvalid;
            d = rdata;
            resp = rresp;
        end
    endtask

    function automatic logic [31:0] ins(input logic [3:0] op, input logic [3:0] cc,
                                        input logic [15:0] p);
        return {8'h00, op, cc, p};
    endfunction

    task automatic load_run(input logic sync);
        foreach (prog[i]) axw(8'h40 + 8'(4 * i), prog[i]);
        ptr_log.delete();
        axw(`BCSE_A_CTRL, {29'h0, sync, 2'b01});
    endtask

    task automatic wait_idle;
        do axr(`BCSE_A_STAT, rd); while (rd[5:4] !== 2'b00);
    endtask

    task automatic load_retry;
        prog = '{ins(4'h3, 4'h0, 16'h1000), ins(4'h2, 4'h2, 16'h0100),
            ins(4'h4, 4'h1, 16'h0009), ins(4'h4, 4'hC, 16'h0006),
            ins(4'h3, 4'h0, 16'h0010), ins(4'h4, 4'h0, 16'h0001),
            ins(4'h5, 4'h0, 16'h0001), ins(4'h6, 4'h0, 16'h0000),
            ins(4'h9, 4'h0, 16'h00A5), ins(4'h0, 4'h0, 16'h0000)};
        load_run(1'b0);
        wait_idle();
    endtask

    task automatic t_reset;
        axr(`BCSE_A_FLAGS, rd); chk(rd, 32'h0);
        axr(`BCSE_A_QPTR, rd); chk(rd, 32'h0);
        axr(`BCSE_A_IMASK, rd); chk(rd, 32'h0);
        axr(8'h24, rd); chk({resp, rd[29:0]}, {2'h2, 30'h0});
        axw(8'h24, 32'h1); chk({30'h0, resp}, 32'h2);
        axw(`BCSE_A_IMASK, 32'h7);
        axr(`BCSE_A_IMASK, rd); chk(rd, 32'h7);
        chk({30'h0, irq, tt_sync_en}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_fault;
        bad_a <= 16'h0100;
        bad_b <= 16'h0110;
        lat <= 8'd30;
        axw(`BCSE_A_FLAGS, 32'h81);
        load_retry();
        chk(32'(ptr_log.size()), 32'h2);
        chk({16'h0, ptr_log[0]}, 32'h0100);
        chk({16'h0, ptr_log[1]}, 32'h0110);
        axr(8'h44, rd); chk(rd, ins(4'h2, 4'h2, 16'h0100));
        axr(`BCSE_A_FLAGS, rd); chk(rd, 32'h91);
        axr(`BCSE_A_QPTR, rd); chk({27'h0, rd[12:8]}, 32'h2);
        axr(`BCSE_A_QDATA, rd); chk(rd, 32'h1);
        axr(`BCSE_A_QDATA, rd); chk(rd, 32'h9110);
        axr(`BCSE_A_UIRQ, rd); chk(rd, 32'hA5);
        axr(`BCSE_A_ISTAT, rd); chk(rd, 32'h7);
        @(posedge clk); chk({31'h0, irq}, 32'h1);
        axw(`BCSE_A_ISTAT, 32'h7);
        @(posedge clk); chk({31'h0, irq}, 32'h0);
        $display("test fault path done");
    endtask

    task automatic t_retry_ok;
        bad_b <= 16'hFFFF;
        lat <= 8'd0;
        load_retry();
        chk({16'h0, ptr_log[1]}, 32'h0110);
        axr(8'h44, rd); chk(rd, ins(4'h2, 4'h2, 16'h0110));
        axr(`BCSE_A_QPTR, rd); chk({27'h0, rd[12:8]}, 32'h0);
        axr(`BCSE_A_ISTAT, rd); chk(rd, 32'h2);
        axr(`BCSE_A_FLAGS, rd); chk(rd, 32'h91);
        $display("test retry done");
    endtask

    task automatic t_log;
        bad_a <= 16'h0200;
        lat <= 8'd5;
        axw(8'h8C, 32'hBEEF);
        prog = '{ins(4'hA, 4'h0, 16'h0), ins(4'hB, 4'h0, 16'h0000),
            ins(4'h1, 4'h0, 16'h0200), ins(4'h5, 4'h0, 16'h1223),
            ins(4'h7, 4'h0, 16'h0003), ins(4'h8, 4'h0, 16'h0),
            ins(4'hB, 4'h0, 16'h4321), ins(4'h0, 4'h0, 16'h0)};
        load_run(1'b1);
        repeat (20) @(posedge clk);
        axr(`BCSE_A_STAT, rd); chk({30'h0, rd[5:4]}, 32'h3);
        trig <= 1'b1;
        repeat (3) @(posedge clk);
        trig <= 1'b0;
        wait_idle();
        @(posedge clk); chk({31'h0, tt_sync_en}, 32'h1);
        chk({16'h0, ptr_log[0]}, 32'h0200);
        axr(8'h48, rd); chk(rd, ins(4'h1, 4'h0, 16'h0200));
        axr(`BCSE_A_QDATA, rd); chk(rd, 32'h1223);
        axr(`BCSE_A_QDATA, rd); chk(rd, 32'hBEEF);
        axr(`BCSE_A_QDATA, rd); chk({31'h0, rd <= 32'h1}, 32'h1);
        axr(`BCSE_A_TTAG, rd); chk({31'h0, rd - 32'h4321 <= 32'h1}, 32'h1);
        chk({31'h0, time_tag - 16'h4321 <= 16'h1}, 32'h1);
        $display("test logging done");
    endtask

    task automatic t_wrap;
        prog.delete();
        for (int i = 0; i < 15; i++) prog.push_back(ins(4'h5, 4'h0, 16'(16 + i)));
        prog.push_back(ins(4'h0, 4'h0, 16'h0));
        load_run(1'b0);
        wait_idle();
        axw(`BCSE_A_CTRL, 32'h1);
        wait_idle();
        axr(`BCSE_A_QPTR, rd); chk({27'h0, rd[12:8]}, 32'h10);
        for (int i = 0; i < 16; i++) begin
            axr(`BCSE_A_QDATA, rd); chk(rd, (i == 0) ? 32'h1E : 32'(15 + i));
        end
        axr(`BCSE_A_QDATA, rd); chk(rd, 32'h0);
        prog = '{ins(4'hA, 4'h0, 16'h0)};
        load_run(1'b0);
        axr(`BCSE_A_STAT, rd); chk(rd, 32'h30);
        axw(`BCSE_A_CTRL, 32'h2);
        axr(`BCSE_A_STAT, rd); chk(rd, 32'h0);
        $display("test queue wrap done");
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, trig} = 6'h0A;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        lat = 8'd0;
        bad_a = 16'hFFFF;
        bad_b = 16'hFFFF;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fault();
        t_retry_ok();
        t_log();
        t_wrap();
        results();
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("timeout reached");
        results();
    end
endmodule
